// File: verilog/ookst_defines.svh
// Constants for the OOK slicer and threshold configuration block
// Function
// - Bit rate is 12800 kHz over 2*(C+1)*(D+1); D resets to 31.
// - One bit-rate timing drives receive recovery and transmit modulator.
// - Transmit filter bits 7..4 hold anti-alias K; host uses 11 for OOK.
// - Receive filter mode bit 7 set selects polyphase band-pass filters.
// - Polyphase centre bits 7..4 hold L; 3 gives 100 kHz.
// - Bandwidth bits 3..0 hold J for polyphase upper cutoff; only 0 or 1 (code passes all four bits, 0 to 15).
// - Bandwidth bits 7..4 select R-C filter, sixteen steps 65 to 987 kHz.
// - Slicer outputs 1 when strength exceeds threshold, else 0.
// - Gain register bits 3..2 pick fixed, peak or average threshold.
// - Fixed mode uses fixed threshold register, 0.5 dB steps, no adjust.
// - Gain register bits 1..0 set IF gain reduction 0 to 13.5 dB.
// - Average mode low-pass filters strength; bits 1..0 select cutoff.
// - Chip rate equals bit rate, doubled with Manchester encoding.
// - Peak mode: strength 6 dB above threshold sets threshold peak-6 dB.
// - Peak mode: each quiet decay interval lowers threshold by decay step.
// - Decay cfg bits 7..5 select step 0.5 to 6.0 dB.
// - Decay cfg bits 4..2 select interval, 8 chips to 1/16 chip.
// - Reset gives 0.5 dB decay step and one decay per chip.
`ifndef OOKST_DEFINES_SVH
`define OOKST_DEFINES_SVH

// Rates in kHz: crystal reference and system clock (50 ns)
`define OOKST_XTAL_KHZ 16'h3200
`define OOKST_CLK_KHZ 16'h4e20
`define OOKST_SUBS_PER_CHIP 18'h00010

// Register byte offsets
`define OOKST_OFF_DIVC 8'h00
`define OOKST_OFF_DIVD 8'h04
`define OOKST_OFF_TXF 8'h08
`define OOKST_OFF_RXMODE 8'h0c
`define OOKST_OFF_CENTER 8'h10
`define OOKST_OFF_BW 8'h14
`define OOKST_OFF_THRGAIN 8'h18
`define OOKST_OFF_FIXTHR 8'h1c
`define OOKST_OFF_DECAY 8'h20
`define OOKST_OFF_CTRL 8'h24
`define OOKST_OFF_STATUS 8'h28

// Reset values
`define OOKST_RST_DIVD 8'h1f
`define OOKST_RST_ZERO 8'h00

// Field positions
`define OOKST_F_HI 7:4
`define OOKST_F_LO 3:0
`define OOKST_F_MODE 3:2
`define OOKST_F_GAIN 1:0
`define OOKST_F_CUT 1:0
`define OOKST_F_STEP 7:5
`define OOKST_F_INTV 4:2
`define OOKST_F_POLY 7
`define OOKST_F_MANCH 0

// 6 dB in 0.5 dB units
`define OOKST_PEAK_MARGIN 8'h0c

// AXI responses
`define OOKST_RESP_OKAY 2'b00
`define OOKST_RESP_SLVERR 2'b10

`endif

// File: verilog/ookst_pkg.sv
// Types for the OOK slicer block
package ookst_pkg;

    typedef enum logic [1:0] {
        OOKST_FIXED  = 2'b00,
        OOKST_PEAK   = 2'b01,
        OOKST_AVG    = 2'b10,
        OOKST_UNUSED = 2'b11
    } ookst_thr_mode_t;

endpackage

// File: verilog/ookst_rate_gen.sv
// Bit-rate divider: crystal, sub-chip, chip and bit enables
`timescale 1ns/1ps
`include "ookst_defines.svh"
module ookst_rate_gen import ookst_pkg::*; (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Divider settings
    input  wire logic [7:0] divC,
    input  wire logic [7:0] divD,
    input  wire logic       manchester,
    // Enables
    output logic            subTick,
    output logic            chipTick,
    output logic            bitTick
);
    logic [15:0] xAcc_q;
    logic [15:0] xSum;
    logic        xTick_q;
    logic [17:0] cPlus;
    logic [17:0] dPlus;
    logic [17:0] prodCD;
    logic [17:0] chipLen;
    logic [17:0] chipCnt_q;
    logic [17:0] subAcc_q;
    logic [17:0] subSum;
    logic        chipEnd;
    logic        chipPar_q;

    // Chip length in crystal periods, halved for Manchester
    assign cPlus   = {10'h000, divC} + 18'h00001;
    assign dPlus   = {10'h000, divD} + 18'h00001;
    assign prodCD  = 18'(cPlus * dPlus);
    assign chipLen = manchester ? prodCD : {prodCD[16:0], 1'b0};
    assign xSum    = xAcc_q + `OOKST_XTAL_KHZ;
    assign subSum  = subAcc_q + `OOKST_SUBS_PER_CHIP;
    assign chipEnd = xTick_q && (chipCnt_q >= chipLen - 18'h00001);

    // Crystal-rate enable from the system clock
    always_ff @(posedge clk) begin
        if (rst) begin
            xAcc_q  <= 16'h0000;
            xTick_q <= 1'b0;
        end else if (xSum >= `OOKST_CLK_KHZ) begin
            xAcc_q  <= xSum - `OOKST_CLK_KHZ;
            xTick_q <= 1'b1;
        end else begin
            xAcc_q  <= xSum;
            xTick_q <= 1'b0;
        end
    end

    // Chip counter
    always_ff @(posedge clk) begin
        if (rst) begin
            chipCnt_q <= 18'h00000;
        end else if (chipEnd) begin
            chipCnt_q <= 18'h00000;
        end else if (xTick_q) begin
            chipCnt_q <= chipCnt_q + 18'h00001;
        end
    end

    // Sixteen sub-chip enables, aligned to chip end
    always_ff @(posedge clk) begin
        if (rst) begin
            subAcc_q <= 18'h00000;
            subTick  <= 1'b0;
        end else if (chipEnd) begin
            subAcc_q <= 18'h00000;
            subTick  <= 1'b1;
        end else if (xTick_q && subSum >= chipLen) begin
            subAcc_q <= subSum - chipLen;
            subTick  <= 1'b1;
        end else begin
            subAcc_q <= xTick_q ? subSum : subAcc_q;
            subTick  <= 1'b0;
        end
    end

    // Chip and bit enables, shared by rx and tx
    always_ff @(posedge clk) begin
        if (rst) begin
            chipTick  <= 1'b0;
            bitTick   <= 1'b0;
            chipPar_q <= 1'b0;
        end else begin
            chipTick  <= chipEnd;
            bitTick   <= chipEnd && (!manchester || chipPar_q);
            chipPar_q <= chipEnd ? !chipPar_q : chipPar_q;
        end
    end

    // Checking helpers: ticks per chip
    logic [17:0] hX_q;
    logic [4:0]  hS_q;
    logic [17:0] lenPrev_q;
    logic        hOk_q;
    always_ff @(posedge clk) begin
        lenPrev_q <= chipLen;
        if (rst) begin
            hX_q  <= 18'h00000;
            hS_q  <= 5'h00;
            hOk_q <= 1'b1;
        end else begin
            hX_q <= (chipTick ? 18'h00000 : hX_q) + {17'h00000, xTick_q};
            hS_q <= (chipTick ? 5'h00 : hS_q) + {4'h0, subTick && !chipTick};
            if (chipLen != lenPrev_q) begin
                hOk_q <= 1'b0;
            end else if (chipTick) begin
                hOk_q <= 1'b1;
            end
        end
    end

    AST_CHIP_LEN: assert property (@(posedge clk) disable iff (rst)
        (chipTick && hOk_q && chipLen == lenPrev_q) |-> hX_q == chipLen)
        else $error("chip length differs from divider setting");
    AST_SUB16: assert property (@(posedge clk) disable iff (rst)
        (chipTick && hOk_q && chipLen == lenPrev_q && chipLen >= 18'h00010) |-> hS_q == 5'h0f)
        else $error("sub-chip enables per chip not sixteen");
    AST_BIT_PLAIN: assert property (@(posedge clk) disable iff (rst)
        (chipTick && !manchester) |-> bitTick ##1 !bitTick)
        else $error("bit enable missing at chip without Manchester");
endmodule

// File: verilog/ookst_avg_filter.sv
// Average threshold: first-order low-pass of signal strength
`timescale 1ns/1ps
`include "ookst_defines.svh"
module ookst_avg_filter import ookst_pkg::*; (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Sample enable, sixteen per chip
    input  wire logic       sampleEn,
    input  wire logic [1:0] cutSel,
    input  wire logic [7:0] rssi,
    // Filtered level
    output logic [7:0]      avgOut
);
    logic [15:0]        acc_q;
    logic signed [16:0] diff;
    logic signed [16:0] delta;

    // Shift 8,6,5,4 gives chip rate over 32,8,4,2 pi
    function automatic logic [3:0] cutShift(input logic [1:0] sel);
        case (sel)
            2'b00:   cutShift = 4'h8;
            2'b01:   cutShift = 4'h6;
            2'b10:   cutShift = 4'h5;
            default: cutShift = 4'h4;
        endcase
    endfunction

    assign diff  = $signed({1'b0, rssi, 8'h00}) - $signed({1'b0, acc_q});
    assign delta = diff >>> cutShift(cutSel);
    assign avgOut = acc_q[15:8];

    // Integrator step per sample
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q <= 16'h0000;
        end else if (sampleEn) begin
            acc_q <= acc_q + delta[15:0];
        end
    end

    AST_AVG_TRACK: assert property (@(posedge clk) disable iff (rst)
        (sampleEn && {rssi, 8'h00} > acc_q)
        |=> (acc_q >= $past(acc_q)) && (acc_q <= {$past(rssi), 8'h00}))
        else $error("average does not move toward strength");
endmodule

// File: verilog/ookst_top.sv
// OOK slicer, threshold and filter configuration with AXI4-Lite registers
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "ookst_defines.svh"
module ookst_top import ookst_pkg::*; (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Signal strength samples
    input  wire logic [7:0]  rssiIn,
    input  wire logic        rssiValid,
    // Demodulated data and bit timing
    output logic             slicedData,
    output logic             rxBitTick,
    output logic             txBitTick,
    // Analog filter and gain settings
    output logic [3:0]       txAntialiasCutoff,
    output logic             polyphaseEn,
    output logic [3:0]       polyphaseCenterFreq,
    output logic [3:0]       polyphaseUpperCutoff,
    output logic [3:0]       rcBandwidthSel,
    output logic [1:0]       ifGainReduce
);
    // Configuration registers
    logic [7:0] divC_q;
    logic [7:0] divD_q;
    logic [7:0] txFilt_q;
    logic [7:0] rxMode_q;
    logic [7:0] center_q;
    logic [7:0] bw_q;
    logic [7:0] thrGain_q;
    logic [7:0] fixThr_q;
    logic [7:0] decay_q;
    logic [7:0] ctrl_q;

    // Bus state
    logic [7:0]  awAddr_q;
    logic        awHave_q;
    logic [31:0] wData_q;
    logic        wStrb0_q;
    logic        wHave_q;
    logic        doWrite;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [1:0]  rresp_q;
    logic [31:0] rdata_q;

    // Slicer state
    ookst_thr_mode_t thrMode;
    logic [7:0]      thr_q;
    logic [7:0]      thrSel;
    logic [7:0]      avgThr;
    logic [7:0]      decayCnt_q;
    logic [7:0]      stepVal;
    logic            decayEvt;
    logic            attack;
    logic            slice_q;
    logic            subTick;
    logic            bitTick;

    // Register offset check, shared by both channels
    function automatic logic isMapped(input logic [7:0] a);
        case ({a[7:2], 2'b00})
            `OOKST_OFF_DIVC, `OOKST_OFF_DIVD, `OOKST_OFF_TXF,
            `OOKST_OFF_RXMODE, `OOKST_OFF_CENTER, `OOKST_OFF_BW,
            `OOKST_OFF_THRGAIN, `OOKST_OFF_FIXTHR, `OOKST_OFF_DECAY,
            `OOKST_OFF_CTRL, `OOKST_OFF_STATUS: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    // Decay step in 0.5 dB units
    function automatic logic [7:0] decayStep(input logic [2:0] sel);
        case (sel)
            3'b000:  decayStep = 8'h01;
            3'b001:  decayStep = 8'h02;
            3'b010:  decayStep = 8'h03;
            3'b011:  decayStep = 8'h04;
            3'b100:  decayStep = 8'h06;
            3'b101:  decayStep = 8'h08;
            3'b110:  decayStep = 8'h0a;
            default: decayStep = 8'h0c;
        endcase
    endfunction

    // Decay interval in sixteenths of a chip
    function automatic logic [7:0] decaySubs(input logic [2:0] sel);
        case (sel)
            3'b000:  decaySubs = 8'h10;
            3'b001:  decaySubs = 8'h20;
            3'b010:  decaySubs = 8'h40;
            3'b011:  decaySubs = 8'h80;
            3'b100:  decaySubs = 8'h08;
            3'b101:  decaySubs = 8'h04;
            3'b110:  decaySubs = 8'h02;
            default: decaySubs = 8'h01;
        endcase
    endfunction

    // Bus handshakes: one write and one read in flight
    assign s_axi_awready = !awHave_q;
    assign s_axi_wready  = !wHave_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign doWrite       = awHave_q && wHave_q && !bvalid_q;

    // Write address and data capture, either order
    always_ff @(posedge clk) begin
        if (rst) begin
            awAddr_q <= 8'h00;
            awHave_q <= 1'b0;
            wData_q  <= 32'h00000000;
            wStrb0_q <= 1'b0;
            wHave_q  <= 1'b0;
        end else if (doWrite) begin
            awHave_q <= 1'b0;
            wHave_q  <= 1'b0;
        end else begin
            if (s_axi_awvalid && !awHave_q) begin
                awAddr_q <= s_axi_awaddr;
                awHave_q <= 1'b1;
            end
            if (s_axi_wvalid && !wHave_q) begin
                wData_q  <= s_axi_wdata;
                wStrb0_q <= s_axi_wstrb[0];
                wHave_q  <= 1'b1;
            end
        end
    end

    // Write response
    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `OOKST_RESP_OKAY;
        end else if (doWrite) begin
            bvalid_q <= 1'b1;
            bresp_q  <= isMapped(awAddr_q) ? `OOKST_RESP_OKAY : `OOKST_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Register writes, low byte lane only
    always_ff @(posedge clk) begin
        if (rst) begin
            divC_q    <= `OOKST_RST_ZERO;
            divD_q    <= `OOKST_RST_DIVD;
            txFilt_q  <= `OOKST_RST_ZERO;
            rxMode_q  <= `OOKST_RST_ZERO;
            center_q  <= `OOKST_RST_ZERO;
            bw_q      <= `OOKST_RST_ZERO;
            thrGain_q <= `OOKST_RST_ZERO;
            fixThr_q  <= `OOKST_RST_ZERO;
            decay_q   <= `OOKST_RST_ZERO;
            ctrl_q    <= `OOKST_RST_ZERO;
        end else if (doWrite && wStrb0_q) begin
            case ({awAddr_q[7:2], 2'b00})
                `OOKST_OFF_DIVC:    divC_q    <= wData_q[7:0];
                `OOKST_OFF_DIVD:    divD_q    <= wData_q[7:0];
                `OOKST_OFF_TXF:     txFilt_q  <= wData_q[7:0];
                `OOKST_OFF_RXMODE:  rxMode_q  <= wData_q[7:0];
                `OOKST_OFF_CENTER:  center_q  <= wData_q[7:0];
                `OOKST_OFF_BW:      bw_q      <= wData_q[7:0];
                `OOKST_OFF_THRGAIN: thrGain_q <= wData_q[7:0];
                `OOKST_OFF_FIXTHR:  fixThr_q  <= wData_q[7:0];
                `OOKST_OFF_DECAY:   decay_q   <= wData_q[7:0];
                `OOKST_OFF_CTRL:    ctrl_q    <= {7'h00, wData_q[`OOKST_F_MANCH]};
                default:            divC_q    <= divC_q;
            endcase
        end
    end

    // Read channel: data latched at address handshake
    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rresp_q  <= `OOKST_RESP_OKAY;
            rdata_q  <= 32'h00000000;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q  <= isMapped(s_axi_araddr) ? `OOKST_RESP_OKAY : `OOKST_RESP_SLVERR;
            case ({s_axi_araddr[7:2], 2'b00})
                `OOKST_OFF_DIVC:    rdata_q <= {24'h000000, divC_q};
                `OOKST_OFF_DIVD:    rdata_q <= {24'h000000, divD_q};
                `OOKST_OFF_TXF:     rdata_q <= {24'h000000, txFilt_q};
                `OOKST_OFF_RXMODE:  rdata_q <= {24'h000000, rxMode_q};
                `OOKST_OFF_CENTER:  rdata_q <= {24'h000000, center_q};
                `OOKST_OFF_BW:      rdata_q <= {24'h000000, bw_q};
                `OOKST_OFF_THRGAIN: rdata_q <= {24'h000000, thrGain_q};
                `OOKST_OFF_FIXTHR:  rdata_q <= {24'h000000, fixThr_q};
                `OOKST_OFF_DECAY:   rdata_q <= {24'h000000, decay_q};
                `OOKST_OFF_CTRL:    rdata_q <= {24'h000000, ctrl_q};
                `OOKST_OFF_STATUS:  rdata_q <= {23'h000000, slice_q, thrSel};
                default:            rdata_q <= 32'h00000000;
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Filter and gain settings to the analog chain
    assign txAntialiasCutoff    = txFilt_q[`OOKST_F_HI];
    assign polyphaseEn          = rxMode_q[`OOKST_F_POLY];
    assign polyphaseCenterFreq  = center_q[`OOKST_F_HI];
    assign polyphaseUpperCutoff = bw_q[`OOKST_F_LO];
    assign rcBandwidthSel       = bw_q[`OOKST_F_HI];
    assign ifGainReduce         = thrGain_q[`OOKST_F_GAIN];

    // Shared bit-rate timing
    ookst_rate_gen uRate (
        .clk        (clk),
        .rst        (rst),
        .divC       (divC_q),
        .divD       (divD_q),
        .manchester (ctrl_q[`OOKST_F_MANCH]),
        .subTick    (subTick),
        .chipTick   (),
        .bitTick    (bitTick)
    );
    assign rxBitTick = bitTick;
    assign txBitTick = bitTick;

    // Average-referenced threshold
    ookst_avg_filter uAvg (
        .clk      (clk),
        .rst      (rst),
        .sampleEn (subTick),
        .cutSel   (decay_q[`OOKST_F_CUT]),
        .rssi     (rssiIn),
        .avgOut   (avgThr)
    );

    // Peak detector terms
    assign thrMode  = ookst_thr_mode_t'(thrGain_q[`OOKST_F_MODE]);
    assign stepVal  = decayStep(decay_q[`OOKST_F_STEP]);
    assign attack   = (thrMode == OOKST_PEAK) && rssiValid
                      && ({1'b0, rssiIn} > {1'b0, thr_q} + {1'b0, `OOKST_PEAK_MARGIN});
    assign decayEvt = subTick
                      && (decayCnt_q >= decaySubs(decay_q[`OOKST_F_INTV]) - 8'h01);

    // Decay interval counter, restarted by each peak
    always_ff @(posedge clk) begin
        if (rst) begin
            decayCnt_q <= 8'h00;
        end else if (attack || decayEvt) begin
            decayCnt_q <= 8'h00;
        end else if (subTick) begin
            decayCnt_q <= decayCnt_q + 8'h01;
        end
    end

    // Fast attack, stepped decay
    always_ff @(posedge clk) begin
        if (rst) begin
            thr_q <= 8'h00;
        end else if (attack) begin
            thr_q <= rssiIn - `OOKST_PEAK_MARGIN;
        end else if (thrMode == OOKST_PEAK && decayEvt) begin
            thr_q <= (thr_q > stepVal) ? thr_q - stepVal : 8'h00;
        end
    end

    // Threshold source by mode; unused code falls back to fixed
    always_comb begin
        case (thrMode)
            OOKST_FIXED: thrSel = fixThr_q;
            OOKST_PEAK:  thrSel = thr_q;
            OOKST_AVG:   thrSel = avgThr;
            default:     thrSel = fixThr_q;
        endcase
    end

    // Slicer decision on each sample
    always_ff @(posedge clk) begin
        if (rst) begin
            slice_q <= 1'b0;
        end else if (rssiValid) begin
            slice_q <= rssiIn > thrSel;
        end
    end
    assign slicedData = slice_q;

    AST_SLICE: assert property (@(posedge clk) disable iff (rst)
        rssiValid |=> slicedData == ($past(rssiIn) > $past(thrSel)))
        else $error("slicer output wrong for sample");
    AST_PEAK_ATTACK: assert property (@(posedge clk) disable iff (rst)
        attack |=> thr_q == $past(rssiIn) - 8'h0c)
        else $error("peak attack did not set threshold 6 dB below");
    AST_DECAY: assert property (@(posedge clk) disable iff (rst)
        (thrMode == OOKST_PEAK && decayEvt && !attack && thr_q > stepVal)
        |=> thr_q == $past(thr_q) - $past(stepVal))
        else $error("threshold decay step wrong");
    AST_HOLD: assert property (@(posedge clk) disable iff (rst)
        (!attack && !decayEvt) |=> $stable(thr_q))
        else $error("threshold moved without peak or decay");
    AST_FIXED: assert property (@(posedge clk) disable iff (rst)
        (thrMode == OOKST_FIXED && rssiValid) |=> slicedData == ($past(rssiIn) > $past(fixThr_q)))
        else $error("fixed mode not using fixed threshold");
    AST_AVG: assert property (@(posedge clk) disable iff (rst)
        (thrGain_q[3:2] == 2'b10 && rssiValid) |=> slicedData == ($past(rssiIn) > $past(avgThr)))
        else $error("average mode not using filtered level");
    AST_DEF_D: assert property (@(posedge clk) disable iff (rst)
        $past(rst) |-> (divD_q == 8'h1f && decay_q == 8'h00))
        else $error("divider D or decay default wrong after reset");
endmodule

// File: sim/ookst_host_model.sv
// Host model: AXI4-Lite master that programs the slicer registers
`timescale 1ns/1ps
module ookst_host_model (
    // Clock
    input  wire logic   clk,
    // Write channels
    output logic [7:0]  awaddr,
    output logic        awvalid,
    input  wire logic   awready,
    output logic [31:0] wdata,
    output logic [3:0]  wstrb,
    output logic        wvalid,
    input  wire logic   wready,
    input  wire logic   bvalid,
    output logic        bready,
    // Read channels
    output logic [7:0]  araddr,
    output logic        arvalid,
    input  wire logic   arready,
    input  wire logic   rvalid,
    output logic        rready
);
    // Responses are always accepted
    initial {awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid} = '0;
    initial {bready, rready} = 2'b11;
    // Offer address and data together, drop each once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aDone, dDone;
        {aDone, dDone} = 2'b00;
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'h1;
        {awvalid, wvalid} <= 2'b11;
        while (!(aDone && dDone)) begin
            @(posedge clk);
            if (awready) begin aDone = 1'b1; awvalid <= 1'b0; end
            if (wready) begin dDone = 1'b1; wvalid <= 1'b0; end
        end
        do @(posedge clk); while (!bvalid);
    endtask
    // Read address, then wait for the data beat
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
    endtask
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the OOK slicer and its registers
`timescale 1ns/1ps
`include "ookst_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end
module tb_top;
    logic        clk = 1'b0, rst = 1'b1, rssiValid = 1'b0;
    logic [7:0]  rssiIn = 8'h00, t, awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, txK, center, upper, rcSel;
    logic [1:0]  bresp, rresp, gain, eB;
    logic [33:0] eR, rq[$];
    logic [1:0]  bq[$];
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic        rvalid, rready, sliced, rxTick, txTick, polyEn;
    int          fails = 0, comparisons = 0, n;
    ookst_top uut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rssiIn(rssiIn), .rssiValid(rssiValid), .slicedData(sliced), .rxBitTick(rxTick),
        .txBitTick(txTick), .txAntialiasCutoff(txK), .polyphaseEn(polyEn),
        .polyphaseCenterFreq(center), .polyphaseUpperCutoff(upper),
        .rcBandwidthSel(rcSel), .ifGainReduce(gain));
    ookst_host_model host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rvalid(rvalid), .rready(rready));
    always #25 clk = ~clk;
    // Oldest expectation against each bus answer
    always @(posedge clk) begin
        if (rvalid && rready) begin eR = rq.pop_front(); `CHK({rresp, rdata}, eR) end
        if (bvalid && bready) begin eB = bq.pop_front(); `CHK(bresp, eB) end
    end
    task automatic wreg(input logic [7:0] a, d, input logic [1:0] r = 2'b00);
        bq.push_back(r);
        host.wr(a, d);
        @(posedge clk);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'b00);
        rq.push_back({r, e});
        host.rd(a);
    endtask
    // One strength sample, slicer checked a cycle later
    task automatic sample(input logic [7:0] v, input logic e);
        rssiIn <= v;
        rssiValid <= 1'b1;
        @(posedge clk);
        rssiValid <= 1'b0;
        @(posedge clk);
        `CHK(sliced, e)
    endtask
    task automatic tick(output int k);
        k = 0;
        do begin @(posedge clk); k++; end while (rxTick !== 1'b1);
    endtask
    task automatic test_done;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        test_done;
    end
    initial begin
        void'($urandom(32864));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rreg(`OOKST_OFF_DIVD, 32'h1f);
        rreg(`OOKST_OFF_DECAY, 32'h0);
        tick(n);
        tick(n);
        `CHK(n inside {[99:101]}, 1'b1)
        `CHK(txTick, 1'b1)
        wreg(`OOKST_OFF_DIVC, 8'h05);
        tick(n);
        tick(n);
        `CHK(n inside {[599:601]}, 1'b1)
        wreg(`OOKST_OFF_CTRL, 8'h01);
        tick(n);
        tick(n);
        `CHK(n inside {[599:601]}, 1'b1)
        wreg(`OOKST_OFF_CTRL, 8'h00);
        $display("end of rate test");
        wreg(`OOKST_OFF_TXF, 8'hb0);
        `CHK(txK, 4'hb)
        wreg(`OOKST_OFF_RXMODE, 8'h80);
        `CHK(polyEn, 1'b1)
        wreg(`OOKST_OFF_CENTER, 8'h30);
        `CHK(center, 4'h3)
        for (int i = 0; i < 16; i++) begin
            wreg(`OOKST_OFF_BW, {i[3:0], 3'h0, i[0]});
            `CHK(rcSel, i[3:0])
            `CHK(upper, {3'h0, i[0]})
        end
        for (int g = 0; g < 4; g++) begin
            wreg(`OOKST_OFF_THRGAIN, {6'h00, g[1:0]});
            `CHK(gain, g[1:0])
        end
        wreg(8'h40, 8'h55, `OOKST_RESP_SLVERR);
        rreg(8'h40, 32'h0, `OOKST_RESP_SLVERR);
        rreg(`OOKST_OFF_TXF, 32'hb0);
        $display("end of config test");
        t = 8'($urandom_range(254, 1));
        wreg(`OOKST_OFF_THRGAIN, 8'h00);
        wreg(`OOKST_OFF_FIXTHR, t);
        sample(t, 1'b0);
        sample(t + 8'h01, 1'b1);
        sample(t - 8'h01, 1'b0);
        $display("end of fixed test");
        wreg(`OOKST_OFF_THRGAIN, 8'h04);
        sample(8'h64, 1'b1);
        sample(8'h59, 1'b1);
        sample(8'h58, 1'b0);
        rreg(`OOKST_OFF_STATUS, 32'h58);
        repeat (1500) @(posedge clk);
        rreg(`OOKST_OFF_STATUS, 32'h56);
        wreg(`OOKST_OFF_DECAY, 8'hfc);
        repeat (400) @(posedge clk);
        rreg(`OOKST_OFF_STATUS, 32'h0);
        $display("end of peak test");
        wreg(`OOKST_OFF_DECAY, 8'h03);
        wreg(`OOKST_OFF_THRGAIN, 8'h08);
        // Alternating one-zero preamble centres the average
        rssiValid <= 1'b1;
        for (int b = 0; b < 24; b++) begin
            rssiIn <= b[0] ? 8'h1e : 8'h5a;
            repeat (600) @(posedge clk);
        end
        sample(8'h5a, 1'b1);
        sample(8'h1e, 1'b0);
        $display("end of average test");
        test_done;
    end
endmodule
